// ### osd_regs_defines.svh
// Register offsets, reset values and display constants of the window 2 and preamp bank
`ifndef OSD_REGS_DEFINES_SVH
`define OSD_REGS_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets (16-bit serial bus register address)
// ---------------------------------------------------------------
`define OFS_W2_VSTART 16'h8419
`define OFS_W2_BASE_LO 16'h841A
`define OFS_W2_BASE_HI 16'h841B
`define OFS_W2_COL_B0 16'h841C
`define OFS_W2_COL_B1 16'h841D
`define OFS_W2_COL_B2 16'h841E
`define OFS_W2_COL_B3 16'h841F
`define OFS_BLUE_GAIN 16'h8430
`define OFS_GREEN_GAIN 16'h8431
`define OFS_RED_GAIN 16'h8432
`define OFS_CONTRAST 16'h8433
`define OFS_DAC_ONE 16'h8434
`define OFS_DAC_TWO 16'h8435
`define OFS_DAC_THREE 16'h8436
`define OFS_ANALOG_CFG 16'h8438

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define BASE_HI_BIT 0
`define GAIN_MSB 6
`define CFG_FS_BIT 5
`define RST_BYTE 8'h00
`define RST_GAIN 7'h00
`define RST_BASE 9'h000
`define RST_COLS 32'h0000_0000

// ---------------------------------------------------------------
// Display constants
// ---------------------------------------------------------------
`define VSTART_SHIFT 1
`define COL_NORMAL_PX 5'h0C
`define COL_WIDE_PX 5'h18
`define BYTE_BITS 4'h8

`endif

// ### osd_regs_pkg.sv
// Types shared by the window 2 and preamp register bank
package osd_regs_pkg;

   // ---------------------------------------------------------------
   // Serial bus slave states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE,
      S_DEV,
      S_DEV_ACK,
      S_AHI,
      S_AHI_ACK,
      S_ALO,
      S_ALO_ACK,
      S_WR,
      S_WR_ACK,
      S_RD,
      S_RD_ACK
   } bus_state_t;

endpackage

// ### osd_window2_preamp_regs.sv
// OSD window 2 and preamp control register bank behind a serial control bus slave
`timescale 1ns/10ps
`include "osd_regs_defines.svh"
// What this block does
// - Window 2 top position equals twice the vertical start register value.
// - Vertical start counts pairs of scan lines, not character lines.
// - Nine low bits of base register give window 2 page RAM start.
// - First RAM location at that base is the first row-start code.
// - Each of 32 bits selects 12 or 24 pixel width for its column.
// - Double-width columns repeat every font pixel on two adjacent positions.
// - Characters beyond the 32nd in a row are always normal width.
// - Blue, green, red gains are seven low bits of three registers.
// - One seven-bit contrast value applies to all three colour channels.
// - DACs one to three each take their own full 8-bit code register.
// - One shared config bit sets full scale of DACs one to three.
// - Full scale is 4.5V with the bit clear, 2.5V with it set.
module osd_window2_preamp_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
   parameter int NUM_WIDE_COLS = 32
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   // Serial control bus pins
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   // Character generator column query
   input wire logic [5:0] COL_INDEX_IN,
   output logic [4:0] COL_WIDTH_PX_OUT,
   output logic PIXEL_REPEAT_OUT,
   // Window 2 placement
   output logic [8:0] WIN2_TOP_LINE_OUT,
   output logic [8:0] WIN2_ROW_START_ADDR_OUT,
   // Video channel gains
   output logic [6:0] BLUE_GAIN_OUT,
   output logic [6:0] GREEN_GAIN_OUT,
   output logic [6:0] RED_GAIN_OUT,
   output logic [6:0] CONTRAST_GAIN_OUT,
   // Bias and brightness DACs
   output logic [7:0] DAC_ONE_OUT,
   output logic [7:0] DAC_TWO_OUT,
   output logic [7:0] DAC_THREE_OUT,
   output logic DAC_FS_LOW_OUT
);
   import osd_regs_pkg::*;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (NUM_WIDE_COLS != 32) begin : g_bad_cols
      $error("Column enable register is fixed at 32 bits");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers and bus events
   // ---------------------------------------------------------------
   logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
   logic sda_s1_reg, sda_s2_reg, sda_s3_reg;

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
         {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
      end else begin
         {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {SCL_IN, scl_s1_reg, scl_s2_reg};
         {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {SDA_IN, sda_s1_reg, sda_s2_reg};
      end
   end

   wire scl_rise = scl_s2_reg & ~scl_s3_reg;
   wire scl_fall = ~scl_s2_reg & scl_s3_reg;
   wire bus_start = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
   wire bus_stop = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

   // ---------------------------------------------------------------
   // Register storage and bus slave state
   // ---------------------------------------------------------------
   logic [7:0] vstart_reg;
   logic [8:0] base_reg;
   logic [31:0] cols_reg;
   logic [6:0] blue_reg, green_reg, red_reg, contrast_reg;
   logic [7:0] dac_one_reg, dac_two_reg, dac_three_reg, cfg_reg;
   bus_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [15:0] addr_reg;
   logic rw_reg;
   logic sda_oe_reg;
   logic mnack_reg;
   logic [7:0] rdata;

   wire byte_done = (bit_cnt_reg == `BYTE_BITS);
   wire dev_match = (shift_reg[7:1] == DEV_ADDR);
   wire wr_en = scl_fall & (state_reg == S_WR) & byte_done;
   wire [15:0] addr_inc = addr_reg + 16'h0001;

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_reg <= S_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= `RST_BYTE;
         addr_reg <= 16'h0000;
         rw_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         mnack_reg <= 1'b0;
      end else if (bus_start) begin
         state_reg <= S_DEV;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (bus_stop) begin
         state_reg <= S_IDLE;
         sda_oe_reg <= 1'b0;
      end else if (scl_rise) begin
         if (state_reg == S_RD_ACK) begin
            mnack_reg <= sda_s2_reg;
         end else if (state_reg == S_DEV || state_reg == S_AHI ||
                      state_reg == S_ALO || state_reg == S_WR) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
      end else if (scl_fall) begin
         unique case (state_reg)
            S_IDLE: sda_oe_reg <= 1'b0;
            S_DEV: begin
               if (byte_done) begin
                  rw_reg <= shift_reg[0];
                  sda_oe_reg <= dev_match;
                  state_reg <= dev_match ? S_DEV_ACK : S_IDLE;
               end
            end
            S_DEV_ACK: begin
               bit_cnt_reg <= rw_reg ? 4'h1 : 4'h0;
               shift_reg <= rdata;
               sda_oe_reg <= rw_reg & ~rdata[7];
               state_reg <= rw_reg ? S_RD : S_AHI;
            end
            S_AHI: begin
               if (byte_done) begin
                  addr_reg[15:8] <= shift_reg;
                  sda_oe_reg <= 1'b1;
                  state_reg <= S_AHI_ACK;
               end
            end
            S_AHI_ACK: begin
               bit_cnt_reg <= 4'h0;
               sda_oe_reg <= 1'b0;
               state_reg <= S_ALO;
            end
            S_ALO: begin
               if (byte_done) begin
                  addr_reg[7:0] <= shift_reg;
                  sda_oe_reg <= 1'b1;
                  state_reg <= S_ALO_ACK;
               end
            end
            S_ALO_ACK, S_WR_ACK: begin
               if (state_reg == S_WR_ACK) begin
                  addr_reg <= addr_inc;
               end
               bit_cnt_reg <= 4'h0;
               sda_oe_reg <= 1'b0;
               state_reg <= S_WR;
            end
            S_WR: begin
               if (byte_done) begin
                  sda_oe_reg <= 1'b1;
                  state_reg <= S_WR_ACK;
               end
            end
            S_RD: begin
               if (byte_done) begin
                  addr_reg <= addr_inc;
                  sda_oe_reg <= 1'b0;
                  state_reg <= S_RD_ACK;
               end else begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  sda_oe_reg <= ~shift_reg[6];
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
            end
            S_RD_ACK: begin
               bit_cnt_reg <= 4'h1;
               shift_reg <= rdata;
               sda_oe_reg <= ~mnack_reg & ~rdata[7];
               state_reg <= mnack_reg ? S_IDLE : S_RD;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Address decode and read-back
   // ---------------------------------------------------------------
   wire sel_vstart = (addr_reg == `OFS_W2_VSTART);
   wire sel_base_lo = (addr_reg == `OFS_W2_BASE_LO);
   wire sel_base_hi = (addr_reg == `OFS_W2_BASE_HI);
   wire sel_col0 = (addr_reg == `OFS_W2_COL_B0);
   wire sel_col1 = (addr_reg == `OFS_W2_COL_B1);
   wire sel_col2 = (addr_reg == `OFS_W2_COL_B2);
   wire sel_col3 = (addr_reg == `OFS_W2_COL_B3);
   wire sel_blue = (addr_reg == `OFS_BLUE_GAIN);
   wire sel_green = (addr_reg == `OFS_GREEN_GAIN);
   wire sel_red = (addr_reg == `OFS_RED_GAIN);
   wire sel_contrast = (addr_reg == `OFS_CONTRAST);
   wire sel_dac_one = (addr_reg == `OFS_DAC_ONE);
   wire sel_dac_two = (addr_reg == `OFS_DAC_TWO);
   wire sel_dac_three = (addr_reg == `OFS_DAC_THREE);
   wire sel_cfg = (addr_reg == `OFS_ANALOG_CFG);

   // Unused gain and base high bits read as zero, config byte reads back whole; unmapped addresses read zero
   assign rdata = sel_vstart ? vstart_reg :
                  sel_base_lo ? base_reg[7:0] :
                  sel_base_hi ? {7'h00, base_reg[8]} :
                  sel_col0 ? cols_reg[7:0] :
                  sel_col1 ? cols_reg[15:8] :
                  sel_col2 ? cols_reg[23:16] :
                  sel_col3 ? cols_reg[31:24] :
                  sel_blue ? {1'b0, blue_reg} :
                  sel_green ? {1'b0, green_reg} :
                  sel_red ? {1'b0, red_reg} :
                  sel_contrast ? {1'b0, contrast_reg} :
                  sel_dac_one ? dac_one_reg :
                  sel_dac_two ? dac_two_reg :
                  sel_dac_three ? dac_three_reg :
                  sel_cfg ? cfg_reg : `RST_BYTE;

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         vstart_reg <= `RST_BYTE;
         base_reg <= `RST_BASE;
         cols_reg <= `RST_COLS;
         {blue_reg, green_reg, red_reg, contrast_reg} <= {4{`RST_GAIN}};
         {dac_one_reg, dac_two_reg, dac_three_reg, cfg_reg} <= {4{`RST_BYTE}};
      end else if (wr_en) begin
         if (sel_vstart) vstart_reg <= shift_reg;
         if (sel_base_lo) base_reg[7:0] <= shift_reg;
         if (sel_base_hi) base_reg[8] <= shift_reg[`BASE_HI_BIT];
         if (sel_col0) cols_reg[7:0] <= shift_reg;
         if (sel_col1) cols_reg[15:8] <= shift_reg;
         if (sel_col2) cols_reg[23:16] <= shift_reg;
         if (sel_col3) cols_reg[31:24] <= shift_reg;
         if (sel_blue) blue_reg <= shift_reg[`GAIN_MSB:0];
         if (sel_green) green_reg <= shift_reg[`GAIN_MSB:0];
         if (sel_red) red_reg <= shift_reg[`GAIN_MSB:0];
         if (sel_contrast) contrast_reg <= shift_reg[`GAIN_MSB:0];
         if (sel_dac_one) dac_one_reg <= shift_reg;
         if (sel_dac_two) dac_two_reg <= shift_reg;
         if (sel_dac_three) dac_three_reg <= shift_reg;
         if (sel_cfg) cfg_reg <= shift_reg;
      end
   end

   // ---------------------------------------------------------------
   // Column width lookup and outputs
   // ---------------------------------------------------------------
   logic [4:0] col_px_reg;
   logic repeat_reg;
   wire col_in_range = (COL_INDEX_IN < 6'(NUM_WIDE_COLS));
   wire col_wide = col_in_range & cols_reg[COL_INDEX_IN[4:0]];

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         col_px_reg <= `COL_NORMAL_PX;
         repeat_reg <= 1'b0;
      end else begin
         col_px_reg <= col_wide ? `COL_WIDE_PX : `COL_NORMAL_PX;
         repeat_reg <= col_wide;
      end
   end

   assign SDA_OUT = 1'b0;
   assign SDA_OE_OUT = sda_oe_reg;
   assign COL_WIDTH_PX_OUT = col_px_reg;
   assign PIXEL_REPEAT_OUT = repeat_reg;
   // Top line in scan lines, twice the vertical start value
   assign WIN2_TOP_LINE_OUT = {vstart_reg, 1'b0};
   assign WIN2_ROW_START_ADDR_OUT = base_reg;
   assign BLUE_GAIN_OUT = blue_reg;
   assign GREEN_GAIN_OUT = green_reg;
   assign RED_GAIN_OUT = red_reg;
   assign CONTRAST_GAIN_OUT = contrast_reg;
   assign DAC_ONE_OUT = dac_one_reg;
   assign DAC_TWO_OUT = dac_two_reg;
   assign DAC_THREE_OUT = dac_three_reg;
   assign DAC_FS_LOW_OUT = cfg_reg[`CFG_FS_BIT];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!ARST_N_IN);

   sequence s_wr(logic sel);
      wr_en && sel;
   endsequence

   property p_top_twice;
      WIN2_TOP_LINE_OUT == ({1'b0, vstart_reg} << `VSTART_SHIFT);
   endproperty
   a_top_twice: assert property (p_top_twice) else $error("Top line not twice start");

   property p_vstart_write;
      s_wr(sel_vstart) |=> WIN2_TOP_LINE_OUT == {$past(shift_reg), 1'b0};
   endproperty
   a_vstart_write: assert property (p_vstart_write) else $error("Start write lost");

   property p_base_write;
      s_wr(sel_base_hi) |=> WIN2_ROW_START_ADDR_OUT[8] == $past(shift_reg[0])
         && WIN2_ROW_START_ADDR_OUT[7:0] == $past(base_reg[7:0]);
   endproperty
   a_base_write: assert property (p_base_write) else $error("Base high write wrong");

   property p_row_start;
      s_wr(sel_base_lo) |=> WIN2_ROW_START_ADDR_OUT[7:0] == $past(shift_reg);
   endproperty
   a_row_start: assert property (p_row_start) else $error("Row start address wrong");

   property p_col_width;
      (COL_INDEX_IN < 6'h20) |=> COL_WIDTH_PX_OUT ==
         ($past(cols_reg[COL_INDEX_IN[4:0]]) ? `COL_WIDE_PX : `COL_NORMAL_PX);
   endproperty
   a_col_width: assert property (p_col_width) else $error("Column width wrong");

   property p_repeat;
      PIXEL_REPEAT_OUT == (COL_WIDTH_PX_OUT == `COL_WIDE_PX);
   endproperty
   a_repeat: assert property (p_repeat) else $error("Repeat flag mismatched");

   property p_beyond_32;
      (COL_INDEX_IN >= 6'h20) |=> COL_WIDTH_PX_OUT == `COL_NORMAL_PX && !PIXEL_REPEAT_OUT;
   endproperty
   a_beyond_32: assert property (p_beyond_32) else $error("Column past 32 widened");

   property p_gain_write;
      s_wr(sel_red) |=> RED_GAIN_OUT == $past(shift_reg[6:0]) && $stable(BLUE_GAIN_OUT);
   endproperty
   a_gain_write: assert property (p_gain_write) else $error("Red gain write wrong");

   property p_contrast_write;
      s_wr(sel_contrast) |=> CONTRAST_GAIN_OUT == $past(shift_reg[6:0]);
   endproperty
   a_contrast_write: assert property (p_contrast_write) else $error("Contrast wrong");

   property p_dac_write;
      s_wr(sel_dac_two) |=> DAC_TWO_OUT == $past(shift_reg) && $stable(DAC_ONE_OUT);
   endproperty
   a_dac_write: assert property (p_dac_write) else $error("DAC two write wrong");

   property p_fs_write;
      s_wr(sel_cfg) |=> DAC_FS_LOW_OUT == $past(shift_reg[5]);
   endproperty
   a_fs_write: assert property (p_fs_write) else $error("Full-scale select wrong");

   property p_hold;
      !wr_en |=> $stable(DAC_THREE_OUT) && $stable(base_reg) && $stable(cols_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("Register changed without write");

endmodule

// ### bus_master_model.sv
// Serial bus master model standing in for the monitor microcontroller
`timescale 1ns/10ps
module bus_master_model (
   // Clock
   input wire logic clk_in,
   // Bus lines
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_pull_out
);
   // ---------------------------------------------------------------
   // Line timing, 8 clocks per bus phase
   // ---------------------------------------------------------------
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // One bit: data set mid-low, sampled mid-high once the line has settled
   task automatic bit_io(input logic b, output logic s);
      sda_pull_out <= ~b;
      wt(4);
      scl_out <= 1'b1;
      wt(4);
      #1 s = sda_in;
      wt(4);
      scl_out <= 1'b0;
      wt(4);
   endtask

   // Start or repeated start
   task automatic start();
      wt(1);
      sda_pull_out <= 1'b0;
      wt(4);
      scl_out <= 1'b1;
      wt(4);
      sda_pull_out <= 1'b1;
      wt(4);
      scl_out <= 1'b0;
      wt(4);
   endtask

   task automatic stop();
      sda_pull_out <= 1'b1;
      wt(4);
      scl_out <= 1'b1;
      wt(4);
      sda_pull_out <= 1'b0;
      wt(8);
   endtask

   // Byte out, MSB first, then the device's acknowledge slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   // Byte in, then our acknowledge, or a not-acknowledge on the last byte
   task automatic recv_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(nack, s);
   endtask
endmodule

// ### tb_top.sv
// Self-checking testbench of the window 2 and preamp register bank
`timescale 1ns/10ps
module tb_top;
   localparam logic [6:0] DEV = 7'h2A;
   logic clk, arst_n, scl, sda, sda_pull, dut_oe, dut_sda, rep, fs_low;
   logic [5:0] col_index;
   logic [4:0] col_w;
   logic [8:0] top_line, row_addr;
   logic [6:0] bg, gg, rg, cg;
   logic [7:0] d1, d2, d3;
   int fails, num_checks;

   // Pulled-up data line
   assign sda = (dut_oe ? dut_sda : 1'b1) & ~sda_pull;

   // ---------------------------------------------------------------
   // Instances
   // ---------------------------------------------------------------
   osd_window2_preamp_regs #(.DEV_ADDR(DEV), .NUM_WIDE_COLS(32)) dut_u (
      .CLK_IN(clk), .ARST_N_IN(arst_n), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(dut_sda), .SDA_OE_OUT(dut_oe), .COL_INDEX_IN(col_index),
      .COL_WIDTH_PX_OUT(col_w), .PIXEL_REPEAT_OUT(rep),
      .WIN2_TOP_LINE_OUT(top_line), .WIN2_ROW_START_ADDR_OUT(row_addr),
      .BLUE_GAIN_OUT(bg), .GREEN_GAIN_OUT(gg), .RED_GAIN_OUT(rg),
      .CONTRAST_GAIN_OUT(cg), .DAC_ONE_OUT(d1), .DAC_TWO_OUT(d2),
      .DAC_THREE_OUT(d3), .DAC_FS_LOW_OUT(fs_low));

   bus_master_model mdl_u (.clk_in(clk), .sda_in(sda), .scl_out(scl),
      .sda_pull_out(sda_pull));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr_seq(input logic [15:0] a, input logic [7:0] d[$]);
      logic ack, ok;
      ok = 1'b1;
      mdl_u.start();
      mdl_u.send_byte({DEV, 1'b0}, ack);
      ok &= ack;
      mdl_u.send_byte(a[15:8], ack);
      ok &= ack;
      mdl_u.send_byte(a[7:0], ack);
      ok &= ack;
      foreach (d[i]) begin
         mdl_u.send_byte(d[i], ack);
         ok &= ack;
      end
      mdl_u.stop();
      chk("write acks", 9'h001, 9'(ok));
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e[$]);
      logic ack;
      logic [7:0] b;
      mdl_u.start();
      mdl_u.send_byte({DEV, 1'b0}, ack);
      mdl_u.send_byte(a[15:8], ack);
      mdl_u.send_byte(a[7:0], ack);
      mdl_u.start();
      mdl_u.send_byte({DEV, 1'b1}, ack);
      chk("read ack", 9'h001, 9'(ack));
      foreach (e[i]) begin
         mdl_u.recv_byte(i == e.size() - 1, b);
         chk("readback", 9'(e[i]), 9'(b));
      end
      mdl_u.stop();
   endtask

   task automatic col_q(input logic [5:0] k, input logic wide);
      @(posedge clk);
      col_index <= k;
      @(posedge clk);
      #1;
      chk("column width", wide ? 9'h018 : 9'h00C, 9'(col_w));
      chk("pixel repeat", 9'(wide), 9'(rep));
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk("top line", 9'h000, top_line);
      chk("row start", 9'h000, row_addr);
      chk("dac one", 9'h000, 9'(d1));
      col_q(6'h00, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_vstart();
      wr_seq(16'h8419, '{8'hA5});
      chk("top line", 9'h14A, top_line);
      rd_chk(16'h8419, '{8'hA5});
      wr_seq(16'h8419, '{8'hFF});
      chk("top line", 9'h1FE, top_line);
      $display("test vstart done");
   endtask

   task automatic t_base();
      wr_seq(16'h841A, '{8'h3C, 8'h01});
      chk("row start", 9'h13C, row_addr);
      rd_chk(16'h841A, '{8'h3C, 8'h01});
      $display("test base done");
   endtask

   task automatic t_cols();
      logic [5:0] k[7] = '{6'h00, 6'h01, 6'h0F, 6'h10, 6'h1F, 6'h20, 6'h3F};
      logic w[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      wr_seq(16'h841C, '{8'h01, 8'h80, 8'h00, 8'h80});
      rd_chk(16'h841C, '{8'h01, 8'h80, 8'h00, 8'h80});
      foreach (k[i]) begin
         col_q(k[i], w[i]);
      end
      $display("test columns done");
   endtask

   task automatic t_preamp();
      wr_seq(16'h8430, '{8'h7F, 8'h01, 8'h40, 8'h55, 8'hFF, 8'h00, 8'h80});
      chk("blue gain", 9'h07F, 9'(bg));
      chk("green gain", 9'h001, 9'(gg));
      chk("red gain", 9'h040, 9'(rg));
      chk("contrast", 9'h055, 9'(cg));
      chk("dac one", 9'h0FF, 9'(d1));
      chk("dac two", 9'h000, 9'(d2));
      chk("dac three", 9'h080, 9'(d3));
      wr_seq(16'h8435, '{8'h5A});
      chk("dac two", 9'h05A, 9'(d2));
      chk("dac three", 9'h080, 9'(d3));
      rd_chk(16'h8430, '{8'h7F, 8'h01, 8'h40, 8'h55, 8'hFF, 8'h5A, 8'h80});
      $display("test preamp done");
   endtask

   task automatic t_fs();
      wr_seq(16'h8438, '{8'h20});
      chk("full scale low", 9'h001, 9'(fs_low));
      wr_seq(16'h8438, '{8'h5F});
      chk("full scale low", 9'h000, 9'(fs_low));
      wr_seq(16'h8437, '{8'h33});
      rd_chk(16'h8436, '{8'h80, 8'h00, 8'h5F});
      $display("test full scale done");
   endtask

   task automatic t_refuse();
      logic ack;
      mdl_u.start();
      mdl_u.send_byte({DEV ^ 7'h01, 1'b0}, ack);
      chk("address ack", 9'h000, 9'(ack));
      mdl_u.send_byte(8'h84, ack);
      mdl_u.stop();
      chk("foreign ack", 9'h000, 9'(ack));
      chk("dac one", 9'h0FF, 9'(d1));
      $display("test refuse done");
   endtask

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      arst_n = 1'b0;
      col_index = 6'h00;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_vstart();
      t_base();
      t_cols();
      t_preamp();
      t_fs();
      t_refuse();
      wrap_up();
   end

   initial begin
      repeat (80000) @(posedge clk);
      fails++;
      $display("mismatch watchdog expected done seen hang");
      wrap_up();
   end
endmodule
